/* File: src/wop_pkg.sv */
// shared constants, register map and carrier types of the warning output block
// assumes a single 20 MHz clock and an APB master with 32-bit data
package wop_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_CYCLES = (MS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HOLD = 8'h04;
  localparam logic [7:0] ADDR_ROUTE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam int CTRL_PIN_SEL_LSB = 0;
  localparam int CTRL_CODE_EN_BIT = 2;
  localparam int CTRL_ALARM_CLR_BIT = 8;
  localparam logic [1:0] PIN_SEL_RESET = 2'h0;
  localparam logic CODE_EN_RESET = 1'b0;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [9:0] HOLD_MIN_MS = 10'h014;
  localparam logic [9:0] HOLD_MAX_MS = 10'h3E8;
  localparam logic [9:0] HOLD_RESET_MS = 10'h014;

  // ----------------------------------------------------------------
  // output encodings, low means ON
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_NONE_N = 3'h7;
  localparam logic [2:0] CODE_OVERLOAD_N = 3'h6;
  localparam logic [2:0] CODE_REGEN_N = 3'h5;
  localparam logic [2:0] PAIRS_OFF_N = 3'h7;
  localparam int NUM_PAIRS = 3;
  localparam int NUM_OTHER = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b00,
    HOLD_COUNT = 2'b01,
    HOLD_EXPIRED = 2'b10
  } wop_hold_state_type;

  typedef struct packed {
    logic [7:0] route;
    logic [9:0] hold_ms;
    logic code_en;
    logic [1:0] pin_sel;
  } wop_cfg_type;

  typedef struct packed {
    logic overload_warn;
    logic regen_warn;
    logic alarm_active;
    logic [2:0] alarm_code;
    logic mains_on;
    logic ctrl_power_ok;
    logic undervolt;
    logic [3:0] other_status;
  } wop_pins_type;

  typedef struct packed {
    logic [2:0] pair_n;
    logic [2:0] code_n;
    logic expired;
    logic servo_alarm;
    logic drive;
    logic mains;
    logic warn;
  } wop_stat_type;

endpackage : wop_pkg

/* File: src/wop_hold_timer.sv */
// momentary power-loss hold timer
// assumes mains_on is already synchronised to pclk
`timescale 1ns/100ps
module wop_hold_timer #(
  parameter int MS_CYCLES = wop_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mains_on,
  input wire logic [9:0] hold_ms,
  output logic expired
);

  localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);

  wop_pkg::wop_hold_state_type state_reg, state_next;
  logic [14:0] pre_reg, pre_next;
  logic [9:0] ms_reg, ms_next;

  // ----------------------------------------------------------------
  // hold sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pre_next = pre_reg;
    ms_next = ms_reg;
    unique case (state_reg)
      wop_pkg::HOLD_IDLE: begin
        pre_next = 15'h0000;
        ms_next = 10'h000;
        if (!mains_on) begin
          state_next = wop_pkg::HOLD_COUNT;
        end
      end
      wop_pkg::HOLD_COUNT: begin
        if (mains_on) begin
          state_next = wop_pkg::HOLD_IDLE;
        end else if (ms_reg >= hold_ms) begin
          state_next = wop_pkg::HOLD_EXPIRED;
        end else if (pre_reg == MS_LAST) begin
          pre_next = 15'h0000;
          ms_next = ms_reg + 10'h001;
        end else begin
          pre_next = pre_reg + 15'h0001;
        end
      end
      wop_pkg::HOLD_EXPIRED: begin
        if (mains_on) begin
          state_next = wop_pkg::HOLD_IDLE;
        end
      end
      default: begin
        state_next = wop_pkg::HOLD_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= wop_pkg::HOLD_IDLE;
      pre_reg <= 15'h0000;
      ms_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      pre_reg <= pre_next;
      ms_reg <= ms_next;
    end
  end

  assign expired = (state_reg == wop_pkg::HOLD_EXPIRED);

endmodule : wop_hold_timer

/* File: src/wop_apb_regs.sv */
// APB slave holding the configuration of the warning output block
// assumes an APB master on pclk; no wait state, pready always from a flop
`timescale 1ns/100ps
module wop_apb_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire wop_pkg::wop_stat_type stat,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output wop_pkg::wop_cfg_type cfg,
  output logic alarm_clr
);

  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic alarm_clr_reg, alarm_clr_next;
  wop_pkg::wop_cfg_type cfg_reg, cfg_next;
  logic setup;
  logic commit;
  logic hold_ok;
  logic err;
  logic [31:0] rd;

  assign setup = psel && !penable;
  assign commit = psel && penable && pready_reg;
  assign hold_ok = (pwdata[31:10] == 22'h000000) && (pwdata[9:0] >= wop_pkg::HOLD_MIN_MS) &&
                   (pwdata[9:0] <= wop_pkg::HOLD_MAX_MS);

  // ----------------------------------------------------------------
  // decode and write
  // ----------------------------------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    alarm_clr_next = 1'b0;
    pready_next = setup;
    err = 1'b0;
    rd = 32'h00000000;
    unique case (paddr)
      wop_pkg::ADDR_CTRL: rd = {29'h00000000, cfg_reg.code_en, cfg_reg.pin_sel};
      wop_pkg::ADDR_HOLD: rd = {22'h000000, cfg_reg.hold_ms};
      wop_pkg::ADDR_ROUTE: rd = {24'h000000, cfg_reg.route};
      wop_pkg::ADDR_STATUS: rd = {21'h000000, stat};
      default: err = 1'b1;
    endcase
    // out of range hold times are refused whole, the old value stays
    if (pwrite && paddr == wop_pkg::ADDR_HOLD && !hold_ok) begin
      err = 1'b1;
    end
    prdata_next = (setup && !pwrite && !err) ? rd : 32'h00000000;
    pslverr_next = setup && err;
    if (commit && pwrite && !pslverr_reg) begin
      unique case (paddr)
        wop_pkg::ADDR_CTRL: begin
          cfg_next.pin_sel = pwdata[wop_pkg::CTRL_PIN_SEL_LSB +: 2];
          cfg_next.code_en = pwdata[wop_pkg::CTRL_CODE_EN_BIT];
          alarm_clr_next = pwdata[wop_pkg::CTRL_ALARM_CLR_BIT];
        end
        wop_pkg::ADDR_HOLD: cfg_next.hold_ms = pwdata[9:0];
        wop_pkg::ADDR_ROUTE: cfg_next.route = pwdata[7:0];
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg.route <= wop_pkg::ROUTE_RESET;
      cfg_reg.hold_ms <= wop_pkg::HOLD_RESET_MS;
      cfg_reg.code_en <= wop_pkg::CODE_EN_RESET;
      cfg_reg.pin_sel <= wop_pkg::PIN_SEL_RESET;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      alarm_clr_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      alarm_clr_reg <= alarm_clr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cfg = cfg_reg;
  assign alarm_clr = alarm_clr_reg;

endmodule : wop_apb_regs

/* File: src/wop_top.sv */
// warning output, warning code and power-loss hold logic of a servo amplifier
// assumes status pins are asynchronous to pclk and a host reads the pairs as interlocks
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module wop_top #(
  parameter int MS_CYCLES = wop_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wop_pkg::wop_pins_type pins,
  output logic [2:0] pair_n,
  output logic [2:0] code_n,
  output logic motor_drive,
  output logic servo_alarm
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wop_pkg::wop_pins_type sync1_reg, sync1_next;
  wop_pkg::wop_pins_type sync2_reg, sync2_next;
  wop_pkg::wop_cfg_type cfg;
  wop_pkg::wop_stat_type stat;
  logic [2:0] pair_n_reg, pair_n_next;
  logic [2:0] code_n_reg, code_n_next;
  logic drive_reg, drive_next;
  logic alarm_reg, alarm_next;
  logic [2:0] pair_hit;
  logic warn;
  logic alarm_any;
  logic alarm_clr;
  logic expired;

  function automatic logic route_hit(input logic [1:0] sel, input int pair);
    route_hit = (sel == 2'(pair + 1));
  endfunction : route_hit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    sync1_next = pins;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ----------------------------------------------------------------
  // register file and hold timer
  // ----------------------------------------------------------------
  wop_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .stat(stat),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg),
    .alarm_clr(alarm_clr)
  );

  wop_hold_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .mains_on(sync2_reg.mains_on),
    .hold_ms(cfg.hold_ms),
    .expired(expired)
  );

  // ----------------------------------------------------------------
  // warning routing
  // ----------------------------------------------------------------
  // control mode does not gate the warning; it is valid in every mode
  assign warn = sync2_reg.overload_warn || sync2_reg.regen_warn;

  // the position_output_a-position output is not built here; its select stays with the host
  genvar gp;
  generate
    for (gp = 0; gp < wop_pkg::NUM_PAIRS; gp++) begin : g_pair
      always_comb begin
        pair_hit[gp] = warn && route_hit(cfg.pin_sel, gp);
        for (int i = 0; i < wop_pkg::NUM_OTHER; i++) begin
          if (sync2_reg.other_status[i] && route_hit(cfg.route[2*i +: 2], gp)) begin
            pair_hit[gp] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs, alarm and drive
  // ----------------------------------------------------------------
  assign alarm_any = alarm_reg || sync2_reg.alarm_active;

  always_comb begin
    pair_n_next = ~pair_hit;
    // alarm has priority; overload is shown before regen when both stand
    if (alarm_any) begin
      code_n_next = ~sync2_reg.alarm_code;
    end else if (!cfg.code_en) begin
      code_n_next = wop_pkg::CODE_NONE_N;
    end else if (sync2_reg.overload_warn) begin
      code_n_next = wop_pkg::CODE_OVERLOAD_N;
    end else if (sync2_reg.regen_warn) begin
      code_n_next = wop_pkg::CODE_REGEN_N;
    end else begin
      code_n_next = wop_pkg::CODE_NONE_N;
    end
    // a new undervoltage event outweighs a clear in the same cycle
    alarm_next = (sync2_reg.undervolt && !sync2_reg.mains_on) ||
                 (alarm_reg && !alarm_clr);
    drive_next = sync2_reg.ctrl_power_ok && !alarm_any && !expired;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_n_reg <= wop_pkg::PAIRS_OFF_N;
      code_n_reg <= wop_pkg::CODE_NONE_N;
      alarm_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      pair_n_reg <= pair_n_next;
      code_n_reg <= code_n_next;
      alarm_reg <= alarm_next;
      drive_reg <= drive_next;
    end
  end

  assign pair_n = pair_n_reg;
  assign code_n = code_n_reg;
  assign motor_drive = drive_reg;
  assign servo_alarm = alarm_reg;
  assign stat = '{pair_n: pair_n_reg, code_n: code_n_reg, expired: expired,
                  servo_alarm: alarm_reg, drive: drive_reg,
                  mains: sync2_reg.mains_on, warn: warn};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_warn_pair_low: assert property (@(posedge pclk) disable iff (!presetn)
    warn && cfg.pin_sel != 2'h0 |=> !pair_n_reg[$past(cfg.pin_sel) - 2'h1])
    else $error("routed warning did not pull its pair low");

  a_pair_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
    !warn && sync2_reg.other_status == 4'h0 |=> pair_n_reg == wop_pkg::PAIRS_OFF_N)
    else $error("pair low with nothing routed active");

  a_unrouted_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.pin_sel == 2'h0 && cfg.route == 8'h00 |=> pair_n_reg == wop_pkg::PAIRS_OFF_N)
    else $error("unallocated warning reached a pair");

  a_pair_or_other: assert property (@(posedge pclk) disable iff (!presetn)
    sync2_reg.other_status[0] && cfg.route[1:0] == 2'h2 |=> !pair_n_reg[1])
    else $error("routed status signal not ORed onto its pair");

  a_code_off_plain: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg.code_en && !alarm_any |=> code_n_reg == wop_pkg::CODE_NONE_N)
    else $error("warning code shown with code output disabled");

  a_code_alarm_wins: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_any |=> code_n_reg == ~$past(sync2_reg.alarm_code))
    else $error("alarm code not shown during alarm");

  a_code_overload: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.code_en && !alarm_any && sync2_reg.overload_warn |=>
      code_n_reg == wop_pkg::CODE_OVERLOAD_N)
    else $error("overload code wrong");

  a_code_regen: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.code_en && !alarm_any && !sync2_reg.overload_warn && sync2_reg.regen_warn |=>
      code_n_reg == wop_pkg::CODE_REGEN_N)
    else $error("regenerative overload code wrong");

  a_hold_range: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.hold_ms >= wop_pkg::HOLD_MIN_MS && cfg.hold_ms <= wop_pkg::HOLD_MAX_MS)
    else $error("hold time outside its range");

  a_expire_drive_off: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(expired) |=> !drive_reg [*2])
    else $error("drive stayed on after hold expired");

  a_short_dip_kept: assert property (@(posedge pclk) disable iff (!presetn)
    drive_reg && $fell(sync2_reg.mains_on) && sync2_reg.ctrl_power_ok &&
      !sync2_reg.alarm_active && !sync2_reg.undervolt |=> drive_reg)
    else $error("drive dropped at start of hold window");

  a_undervolt_alarm: assert property (@(posedge pclk) disable iff (!presetn)
    sync2_reg.undervolt && !sync2_reg.mains_on |=> alarm_reg ##1 !drive_reg)
    else $error("undervoltage in power loss raised no servo alarm");

  a_ctrl_loss: assert property (@(posedge pclk) disable iff (!presetn)
    !sync2_reg.ctrl_power_ok |=> !drive_reg)
    else $error("drive on without control power");

  a_return_clears: assert property (@(posedge pclk) disable iff (!presetn)
    expired && sync2_reg.mains_on |=> !expired)
    else $error("hold state not cleared when mains returned");

  c_warn_routed: cover property (@(posedge pclk) disable iff (!presetn)
    warn && cfg.pin_sel == 2'h3 ##1 !pair_n_reg[2]);

  c_hold_expired: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(expired));

  c_dip_ridden: cover property (@(posedge pclk) disable iff (!presetn)
    drive_reg && !sync2_reg.mains_on ##[1:100] sync2_reg.mains_on && drive_reg);

  c_alarm_code: cover property (@(posedge pclk) disable iff (!presetn)
    cfg.code_en && alarm_any ##1 code_n_reg != wop_pkg::CODE_NONE_N);

endmodule : wop_top

/* File: tb/wop_host_model.sv */
// host controller model that reads the terminal pairs as interlocks
// assumes pair outputs are levels in the pclk domain
`timescale 1ns/100ps
module wop_host_model #(
  // position_output_a stays unallocated until the host picks a pair
  parameter logic [15:0] POSITION_OUTPUT_A_OUT_SELECT = 16'h0000
) (
  input wire logic pclk,
  input wire logic [2:0] pair_n,
  output logic [2:0] pair_closed
);
  // ----------------------------------------------------------------
  // interlock sampling
  // ----------------------------------------------------------------
  // low level reads as a closed contact; registered like a real input stage
  always_ff @(posedge pclk) begin
    pair_closed <= ~pair_n;
  end
endmodule : wop_host_model

/* File: tb/warning_output_and_power_hold_test.sv */
// self-checking bench of the warning output and power-loss hold block
// assumes the design package is compiled first; MS_CYCLES shortened to 20
`timescale 1ns/100ps
module warning_output_and_power_hold_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int MSC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, motor_drive, servo_alarm, obs;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rng;
  logic [2:0] pair_n, code_n, host_closed, p, cd;
  wop_pkg::wop_pins_type pins;
  logic [32:0] apb_q[$];
  logic [7:0] out_q[$];
  int n_mismatch, cmp_count, s, c, w, k;

  wop_top #(.MS_CYCLES(MSC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .pair_n(pair_n), .code_n(code_n),
    .motor_drive(motor_drive), .servo_alarm(servo_alarm));
  wop_host_model u_host (.pclk(pclk), .pair_n(pair_n), .pair_closed(host_closed));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic check_bus(input logic [32:0] ex, input logic [32:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("wrong value bus err_data expected %h seen %h", ex, got);
    end
  endtask : check_bus

  task automatic check_pins(input logic [7:0] ex, input logic [7:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("wrong value pair_code_drive_alarm expected %h seen %h", ex, got);
    end
  endtask : check_pins

  // request held until pready is seen; one idle edge after so psel is never set twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    int i;
    apb_q.push_back(ex);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // pins need 3 edges plus one for the host stage; 6 leaves margin
  task automatic expect_out(input logic [7:0] ex);
    repeat (6) @(posedge pclk);
    out_q.push_back(ex);
    obs <= 1'b1;
    @(posedge pclk);
    obs <= 1'b0;
  endtask : expect_out

  // ----------------------------------------------------------------
  // monitor
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (apb_q.size() == 0) n_mismatch++;
      else check_bus(apb_q.pop_front(), {pslverr, prdata});
    end
    if (obs) begin
      if (out_q.size() == 0) n_mismatch++;
      else check_pins(out_q.pop_front(), {~host_closed, code_n, motor_drive, servo_alarm});
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, obs} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rng = 32'h158D8;
    pins = '0;
    pins.mains_on = 1'b1;
    pins.ctrl_power_ok = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, wop_pkg::ADDR_CTRL, 32'h0, {1'b0, 32'h0});
    apb(1'b0, wop_pkg::ADDR_HOLD, 32'h0, {1'b0, 32'h14});
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    expect_out(8'hFE);
    apb(1'b1, wop_pkg::ADDR_HOLD, 32'h13, {1'b1, 32'h0});
    apb(1'b1, wop_pkg::ADDR_HOLD, 32'h3E9, {1'b1, 32'h0});
    apb(1'b0, wop_pkg::ADDR_HOLD, 32'h0, {1'b0, 32'h14});
    apb(1'b1, wop_pkg::ADDR_HOLD, 32'h3E8, {1'b0, 32'h0});
    apb(1'b0, wop_pkg::ADDR_HOLD, 32'h0, {1'b0, 32'h3E8});
    apb(1'b1, wop_pkg::ADDR_HOLD, 32'h14, {1'b0, 32'h0});
    // every select, both code settings, both warning kinds
    for (s = 0; s < 4; s++) for (c = 0; c < 2; c++) for (w = 1; w < 3; w++) begin
      apb(1'b1, wop_pkg::ADDR_CTRL, {29'h0, c[0], s[1:0]}, {1'b0, 32'h0});
      pins.overload_warn <= w[0];
      pins.regen_warn <= w[1];
      p = 3'h7;
      if (s != 0) p[s-1] = 1'b0;
      cd = (c == 0) ? 3'h7 : ((w == 1) ? 3'h6 : 3'h5);
      expect_out({p, cd, 2'b10});
      pins.overload_warn <= 1'b0;
      pins.regen_warn <= 1'b0;
    end
    // random other signals sharing pairs with the warning
    apb(1'b1, wop_pkg::ADDR_ROUTE, 32'h39, {1'b0, 32'h0});
    apb(1'b1, wop_pkg::ADDR_CTRL, 32'h1, {1'b0, 32'h0});
    repeat (8) begin
      rng = xs(rng);
      pins.other_status <= rng[3:0];
      pins.overload_warn <= rng[4];
      p = ~{rng[2], rng[1], rng[0] | rng[4]};
      expect_out({p, 3'h7, 2'b10});
    end
    pins.other_status <= 4'h0;
    pins.overload_warn <= 1'b0;
    apb(1'b1, wop_pkg::ADDR_CTRL, 32'h4, {1'b0, 32'h0});
    pins.overload_warn <= 1'b1;
    pins.alarm_active <= 1'b1;
    pins.alarm_code <= 3'h5;
    expect_out(8'hE8);
    pins.overload_warn <= 1'b0;
    pins.alarm_active <= 1'b0;
    pins.alarm_code <= 3'h0;
    // two short losses; together longer than the hold, so the timer must clear
    for (k = 0; k < 2; k++) begin
      pins.mains_on <= 1'b0;
      repeat (293) @(posedge pclk);
      expect_out(8'hFE);
      pins.mains_on <= 1'b1;
      repeat (10) @(posedge pclk);
    end
    pins.mains_on <= 1'b0;
    repeat (373) @(posedge pclk);
    expect_out(8'hFE);
    repeat (53) @(posedge pclk);
    expect_out(8'hFC);
    pins.mains_on <= 1'b1;
    expect_out(8'hFE);
    pins.mains_on <= 1'b0;
    pins.undervolt <= 1'b1;
    expect_out(8'hFD);
    pins.mains_on <= 1'b1;
    pins.undervolt <= 1'b0;
    apb(1'b1, wop_pkg::ADDR_CTRL, 32'h100, {1'b0, 32'h0});
    expect_out(8'hFE);
    pins.ctrl_power_ok <= 1'b0;
    expect_out(8'hFC);
    pins.ctrl_power_ok <= 1'b1;
    expect_out(8'hFE);
    complete_run();
  end
endmodule : warning_output_and_power_hold_test
